// ---- src/brg_pkg.sv ----
package brg_pkg;
  localparam int unsigned NUM_CH = 2;
  localparam int unsigned CLK_HZ = 25000000;
  // per channel: divisor at base, mode at base+4; channel stride 0x10
  localparam logic [11:0] CH_STRIDE        = 12'h010;
  localparam logic [11:0] OFF_DIVISOR      = 12'h000;
  localparam logic [11:0] OFF_MODE         = 12'h004;
  localparam logic [11:0] OFF_STATUS       = 12'h008;
  localparam logic [7:0]  DIVISOR_RESET    = 8'hff;
  localparam logic [1:0]  PRESCALE_RESET   = 2'h0;
  localparam int unsigned PRESCALE_LO_BIT  = 0;
  localparam int unsigned PRESCALE_HI_BIT  = 1;
  localparam int unsigned BIT_SUBSTEPS     = 16;
  localparam int unsigned PRESCALE_W       = 7;

  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } brg_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } brg_apb_rsp_t;
endpackage

// ---- src/brg_channel.sv ----
`timescale 1ns/1ps
module brg_channel
  import brg_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       standby,
  input  wire logic [7:0] divisor,
  input  wire logic [1:0] prescale_sel,
  output logic            clk16_en,
  output logic            bit_en
);
  typedef struct packed {
    logic [PRESCALE_W-1:0] pre;
    logic [7:0]            cnt;
    logic [3:0]            sub;
    logic                  clk16;
    logic                  bit_tick;
  } brg_ch_state_t;

  brg_ch_state_t st_q;
  brg_ch_state_t st_d;
  logic          pre_tick;

  // source tick every 2*4^n system clocks; the counter wraps at 128 so every tap is exact
  always_comb begin
    case (prescale_sel)
      2'h0:    pre_tick = st_q.pre[0] == 1'b1;
      2'h1:    pre_tick = st_q.pre[2:0] == 3'h7;
      2'h2:    pre_tick = st_q.pre[4:0] == 5'h1f;
      default: pre_tick = st_q.pre[6:0] == 7'h7f;
    endcase
  end

  always_comb begin
    st_d          = st_q;
    st_d.clk16    = 1'b0;
    st_d.bit_tick = 1'b0;
    st_d.pre      = st_q.pre + PRESCALE_W'(1);
    if (pre_tick) begin
      if (st_q.cnt >= divisor) begin
        st_d.cnt   = 8'h00;
        st_d.clk16 = 1'b1;
        st_d.sub   = st_q.sub + 4'h1;
        if (st_q.sub == 4'hf) begin
          st_d.bit_tick = 1'b1;
        end
      end else begin
        st_d.cnt = st_q.cnt + 8'h01;
      end
    end
    if (standby) begin
      st_d = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign clk16_en = st_q.clk16;
  assign bit_en   = st_q.bit_tick;
endmodule

// ---- src/brg_top.sv ----
`timescale 1ns/1ps
module brg_top
  import brg_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 standby,
  input  wire brg_pkg::brg_apb_req_t apb_req,
  output brg_pkg::brg_apb_rsp_t     apb_rsp,
  output logic [NUM_CH-1:0]         clk16_en,
  output logic [NUM_CH-1:0]         bit_en
);
  import brg_pkg::*;

  typedef struct packed {
    logic [NUM_CH-1:0][7:0] divisor;
    logic [NUM_CH-1:0][1:0] prescale;
    logic [NUM_CH-1:0]      bit_seen;
    logic [31:0]            rdata;
    logic                   err;
  } brg_top_state_t;

  brg_top_state_t st_q;
  brg_top_state_t st_d;
  logic           access;
  logic           wr;
  logic           rd;
  logic           hit_div;
  logic           hit_mode;
  logic           hit_stat;
  logic [11:0]    local_off;
  logic [3:0]     ch_idx;

  assign access    = apb_req.psel && apb_req.penable;
  assign wr        = access && apb_req.pwrite;
  assign rd        = access && !apb_req.pwrite;
  assign ch_idx    = apb_req.paddr[7:4];
  assign local_off = apb_req.paddr & (CH_STRIDE - 12'h001);

  always_comb begin
    hit_div  = 1'b0;
    hit_mode = 1'b0;
    hit_stat = 1'b0;
    if (apb_req.paddr[11:8] != 4'h0 || ch_idx >= 4'(NUM_CH)) begin
      hit_div = 1'b0;
    end else if (local_off == OFF_DIVISOR) begin
      hit_div = 1'b1;
    end else if (local_off == OFF_MODE) begin
      hit_mode = 1'b1;
    end else if (local_off == OFF_STATUS) begin
      hit_stat = 1'b1;
    end
  end

  always_comb begin
    st_d       = st_q;
    st_d.err   = 1'b0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (bit_en[i]) begin
        st_d.bit_seen[i] = 1'b1;
      end
    end
    if (access) begin
      st_d.err = !(hit_div || hit_mode || hit_stat);
    end
    // no busy gating: writes land mid-character by design
    if (wr && hit_div) begin
      st_d.divisor[ch_idx[0]] = apb_req.pwdata[7:0];
    end
    if (wr && hit_mode) begin
      st_d.prescale[ch_idx[0]] = {apb_req.pwdata[PRESCALE_HI_BIT],
                                  apb_req.pwdata[PRESCALE_LO_BIT]};
    end
    if (rd) begin
      st_d.rdata = 32'h0000_0000;
      if (hit_div) begin
        st_d.rdata = {24'h00_0000, st_q.divisor[ch_idx[0]]};
      end else if (hit_mode) begin
        st_d.rdata = {30'h0000_0000, st_q.prescale[ch_idx[0]]};
      end else if (hit_stat) begin
        st_d.rdata = {31'h0000_0000, st_q.bit_seen[ch_idx[0]]};
        // read clears, but a tick in the same cycle stays set
        st_d.bit_seen[ch_idx[0]] = bit_en[ch_idx[0]];
      end
    end
    if (standby) begin
      for (int i = 0; i < NUM_CH; i++) begin
        st_d.divisor[i] = DIVISOR_RESET;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q          <= '0;
      st_q.divisor  <= {NUM_CH{DIVISOR_RESET}};
      st_q.prescale <= {NUM_CH{PRESCALE_RESET}};
    end else begin
      st_q <= st_d;
    end
  end

  // two-cycle access phase; read data registered in setup-to-access edge
  // is avoided: data sampled the edge after, so add one wait state
  logic wait_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= access && !wait_q;
    end
  end

  assign apb_rsp.pready  = wait_q;
  assign apb_rsp.prdata  = st_q.rdata;
  assign apb_rsp.pslverr = wait_q && st_q.err;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      brg_channel u_ch (
        .pclk         (pclk),
        .presetn      (presetn),
        .standby      (standby),
        .divisor      (st_q.divisor[g]),
        .prescale_sel (st_q.prescale[g]),
        .clk16_en     (clk16_en[g]),
        .bit_en       (bit_en[g])
      );
    end
  endgenerate

  // assertions
  property p_div_reset;
    @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> st_q.divisor == {NUM_CH{DIVISOR_RESET}};
  endproperty
  a_div_reset: assert property (p_div_reset) else $error("divisor not ff after reset");

  property p_standby_ff;
    @(posedge pclk) disable iff (!presetn)
      standby |=> st_q.divisor[0] == DIVISOR_RESET && st_q.divisor[1] == DIVISOR_RESET;
  endproperty
  a_standby_ff: assert property (p_standby_ff) else $error("standby did not set divisor");

  property p_write_div;
    @(posedge pclk) disable iff (!presetn)
      (wr && hit_div && !standby) |=> st_q.divisor[$past(ch_idx[0])] == $past(apb_req.pwdata[7:0]);
  endproperty
  a_write_div: assert property (p_write_div) else $error("divisor write lost");

  property p_ch_indep;
    @(posedge pclk) disable iff (!presetn)
      (wr && hit_div && !standby && ch_idx[0] == 1'b0) |=> $stable(st_q.divisor[1]);
  endproperty
  a_ch_indep: assert property (p_ch_indep) else $error("channel one disturbed");

  property p_write_mode;
    @(posedge pclk) disable iff (!presetn)
      (wr && hit_mode) |=> st_q.prescale[$past(ch_idx[0])] == $past(apb_req.pwdata[1:0]);
  endproperty
  a_write_mode: assert property (p_write_mode) else $error("prescale write lost");

  property p_bit_width;
    @(posedge pclk) disable iff (!presetn)
      (rd && hit_div && !wait_q) |=> apb_rsp.prdata[31:8] == 24'h00_0000;
  endproperty
  a_bit_width: assert property (p_bit_width) else $error("divisor width");

  sequence s_fast_tick;
    st_q.prescale[0] == 2'h0 && st_q.divisor[0] == 8'h00 && !standby;
  endsequence
  property p_fast_rate;
    @(posedge pclk) disable iff (!presetn)
      (s_fast_tick [*8]) ##0 clk16_en[0] ##1 s_fast_tick |-> ##1 clk16_en[0];
  endproperty
  a_fast_rate: assert property (p_fast_rate) else $error("clk16 period wrong");

  property p_read_div;
    @(posedge pclk) disable iff (!presetn)
      (rd && hit_div && !wait_q) |-> ##1 apb_rsp.pready ##0
        apb_rsp.prdata[7:0] == st_q.divisor[$past(ch_idx[0])];
  endproperty
  a_read_div: assert property (p_read_div) else $error("divisor read wrong");

  // bus handshake: exactly one wait state per access
  sequence s_access_start;
    access && !wait_q;
  endsequence

  property p_pready_after_access;
    @(posedge pclk) disable iff (!presetn)
      s_access_start |=> apb_rsp.pready;
  endproperty
  a_pready_after_access: assert property (p_pready_after_access) else $error("pready late");

  property p_pready_pulse;
    @(posedge pclk) disable iff (!presetn)
      apb_rsp.pready |=> !apb_rsp.pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse) else $error("pready too long");

  property p_no_ready_idle;
    @(posedge pclk) disable iff (!presetn)
      !access |=> !apb_rsp.pready;
  endproperty
  a_no_ready_idle: assert property (p_no_ready_idle) else $error("pready without access");

  property p_slverr_with_ready;
    @(posedge pclk) disable iff (!presetn)
      apb_rsp.pslverr |-> apb_rsp.pready;
  endproperty
  a_slverr_with_ready: assert property (p_slverr_with_ready) else $error("stray pslverr");

  property p_unmapped_err;
    @(posedge pclk) disable iff (!presetn)
      s_access_start ##0 !(hit_div || hit_mode || hit_stat) |=> apb_rsp.pslverr;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped not flagged");

  property p_mapped_ok;
    @(posedge pclk) disable iff (!presetn)
      s_access_start ##0 (hit_div || hit_mode || hit_stat) |=> !apb_rsp.pslverr;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok) else $error("mapped access flagged");

  property p_err_quiet;
    @(posedge pclk) disable iff (!presetn)
      !access |=> !st_q.err;
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("error flag without access");

  // register contents move only on their own write or on standby
  property p_div_hold;
    @(posedge pclk) disable iff (!presetn)
      (!(wr && hit_div) && !standby) |=> $stable(st_q.divisor);
  endproperty
  a_div_hold: assert property (p_div_hold) else $error("divisor changed unasked");

  property p_unmapped_no_write;
    @(posedge pclk) disable iff (!presetn)
      (wr && !(hit_div || hit_mode || hit_stat)) |=> $stable(st_q.prescale);
  endproperty
  a_unmapped_no_write: assert property (p_unmapped_no_write) else $error("unmapped write landed");

  property p_mode_hold;
    @(posedge pclk) disable iff (!presetn)
      !(wr && hit_mode) |=> $stable(st_q.prescale);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("prescale changed unasked");

  property p_ch_indep_one;
    @(posedge pclk) disable iff (!presetn)
      (wr && hit_div && !standby && ch_idx[0] == 1'b1) |=> $stable(st_q.divisor[0]);
  endproperty
  a_ch_indep_one: assert property (p_ch_indep_one) else $error("channel zero disturbed");

  property p_ch_indep_mode;
    @(posedge pclk) disable iff (!presetn)
      (wr && hit_mode && ch_idx[0] == 1'b0) |=> $stable(st_q.prescale[1]);
  endproperty
  a_ch_indep_mode: assert property (p_ch_indep_mode) else $error("prescale one disturbed");

  property p_standby_hold;
    @(posedge pclk) disable iff (!presetn)
      standby ##1 standby |-> st_q.divisor == {NUM_CH{DIVISOR_RESET}};
  endproperty
  a_standby_hold: assert property (p_standby_hold) else $error("divisor left standby value");

  property p_standby_quiet;
    @(posedge pclk) disable iff (!presetn)
      standby |=> clk16_en == '0 && bit_en == '0;
  endproperty
  a_standby_quiet: assert property (p_standby_quiet) else $error("generator ran in standby");

  property p_read_mode;
    @(posedge pclk) disable iff (!presetn)
      (rd && hit_mode && !wait_q) |=>
        apb_rsp.prdata == {30'h0000_0000, st_q.prescale[$past(ch_idx[0])]};
  endproperty
  a_read_mode: assert property (p_read_mode) else $error("prescale read wrong");

  property p_rdata_hold;
    @(posedge pclk) disable iff (!presetn)
      !rd |=> $stable(st_q.rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  // a bit tick is always also a 16x tick
  property p_bit_on_clk16_a;
    @(posedge pclk) disable iff (!presetn)
      bit_en[0] |-> clk16_en[0];
  endproperty
  a_bit_on_clk16_a: assert property (p_bit_on_clk16_a) else $error("lone bit tick ch0");

  property p_bit_on_clk16_b;
    @(posedge pclk) disable iff (!presetn)
      bit_en[1] |-> clk16_en[1];
  endproperty
  a_bit_on_clk16_b: assert property (p_bit_on_clk16_b) else $error("lone bit tick ch1");

  property p_stat_set;
    @(posedge pclk) disable iff (!presetn)
      bit_en[0] |=> st_q.bit_seen[0];
  endproperty
  a_stat_set: assert property (p_stat_set) else $error("tick not recorded");

  property p_stat_sticky;
    @(posedge pclk) disable iff (!presetn)
      (st_q.bit_seen[0] && !(rd && hit_stat && ch_idx[0] == 1'b0)) |=> st_q.bit_seen[0];
  endproperty
  a_stat_sticky: assert property (p_stat_sticky) else $error("tick flag lost");
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import brg_pkg::*;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              standby = 1'b0;
  brg_apb_req_t      req = '0;
  brg_apb_rsp_t      rsp;
  logic [NUM_CH-1:0] clk16_en;
  logic [NUM_CH-1:0] bit_en;
  logic [32:0]       exp_q[$];
  int                err_total = 0;
  int                samples_checked = 0;
  int                seed = 32'h7852;

  brg_top i_brg_top (
    .pclk     (pclk),
    .presetn  (presetn),
    .standby  (standby),
    .apb_req  (req),
    .apb_rsp  (rsp),
    .clk16_en (clk16_en),
    .bit_en   (bit_en)
  );

  always #20 pclk = ~pclk;

  task automatic end_of_test;
    if (err_total == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(string what, logic [32:0] exp, logic [32:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask

  function automatic logic [11:0] ad(int ch, logic [11:0] off);
    return 12'(ch) * CH_STRIDE + off;
  endfunction

  // pready sampled at the rising edge; one idle edge keeps two calls apart
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    int n;
    req.paddr <= a;
    req.pwrite <= wr;
    req.pwdata <= d;
    req.psel <= 1'b1;
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge pclk);
    if (n >= 20) begin
      err_total++;
      end_of_test();
    end
  endtask

  task automatic rdchk(logic [11:0] a, logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  // third pulse measured so a reprogramming mid-count does not skew it
  task automatic per(int ch, int exp);
    int n;
    int m;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      m = 0;
      do begin
        @(posedge pclk);
        n++;
        if (clk16_en[ch] === 1'b1)
          m++;
      end while (bit_en[ch] !== 1'b1 && n < 9000);
    end
    chk("bit period", 33'(exp), 33'(n));
    chk("clk16 per bit", 33'd16, 33'(m));
    if (n >= 9000)
      end_of_test();
  endtask

  always @(posedge pclk) begin
    if (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite && exp_q.size() > 0)
      chk("read", exp_q.pop_front(), {rsp.pslverr, rsp.prdata});
  end

  initial begin
    logic [31:0] w;
    int          c;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < NUM_CH; i++) begin
      rdchk(ad(i, OFF_DIVISOR), {25'h0, DIVISOR_RESET});
      rdchk(ad(i, OFF_MODE), {31'h0, PRESCALE_RESET});
    end
    repeat (6) begin
      w = $random(seed);
      c = {$random(seed)} % NUM_CH;
      apb(1'b1, ad(c, OFF_DIVISOR), w);
      rdchk(ad(c, OFF_DIVISOR), {25'h0, w[7:0]});
    end
    apb(1'b1, 12'h0fc, 32'hffffffff);
    rdchk(12'h0fc, {1'b1, 32'h0});
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, ad(0, OFF_DIVISOR), 32'(p));
      apb(1'b1, ad(0, OFF_MODE), 32'(p));
      apb(1'b1, ad(1, OFF_DIVISOR), 32'(3 - p));
      apb(1'b1, ad(1, OFF_MODE), 32'(3 - p));
      rdchk(ad(0, OFF_MODE), {31'h0, 2'(p)});
      rdchk(ad(1, OFF_DIVISOR), {25'h0, 8'(3 - p)});
      per(0, 32 * (4 ** p) * (p + 1));
      per(1, 32 * (4 ** (3 - p)) * (4 - p));
    end
    standby <= 1'b1;
    repeat (2) @(posedge pclk);
    standby <= 1'b0;
    @(posedge pclk);
    rdchk(ad(0, OFF_DIVISOR), {25'h0, DIVISOR_RESET});
    rdchk(ad(1, OFF_DIVISOR), {25'h0, DIVISOR_RESET});
    rdchk(ad(0, OFF_MODE), {31'h0, 2'h3});
    rdchk(ad(0, OFF_STATUS), {32'h0, 1'b1});
    rdchk(ad(0, OFF_STATUS), 33'h0);
    repeat (2) @(posedge pclk);
    end_of_test();
  end
endmodule
